// >>> core/fail_safe_clock_monitor.sv
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module fail_safe_clock_monitor
   import fail_safe_clock_monitor_pkg::*;
#(
   parameter int OST_LEN = OST_CYCLES
)(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ext_osc,
   input  wire logic        low_freq_internal_osc,
   input  wire logic        wake_up,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   output logic             sys_clk_internal,
   output logic [2:0]       internal_freq_select,
   output logic             startup_settled_status,
   output logic             fail_safe_active
);

   // =========================================================
   // Helpers
   function automatic logic skip_ost(input logic [2:0] m);
      skip_ost = (m == MODE_EC) || (m == MODE_RC);
   endfunction

   // Places a flag or a three-bit field into a read word
   function automatic logic [31:0] put_bit(input logic b, input int pos);
      put_bit      = WORD_ZERO;
      put_bit[pos] = b;
   endfunction

   function automatic logic [31:0] put3(input logic [2:0] v, input int lsb);
      put3           = WORD_ZERO;
      put3[lsb +: 3] = v;
   endfunction

   // =========================================================
   // Pin synchronisers
   logic ext_s1;
   logic ext_s2;
   logic ext_s3;
   logic lf_s1;
   logic lf_s2;
   logic lf_s3;

   // Two flops settle the pin, the third only feeds the edge detect
   always_ff @(posedge clk) begin
      ext_s1 <= ext_osc;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
   end

   always_ff @(posedge clk) begin
      lf_s1 <= low_freq_internal_osc;
      lf_s2 <= lf_s1;
      lf_s3 <= lf_s2;
   end

   wire ext_fall = ext_s3 & ~ext_s2;
   wire lf_rise  = lf_s2 & ~lf_s3;

   // =========================================================
   // Registers
   config_t    cfg;
   osc_ctl_t   ctl;
   logic       osc_fail_flag;
   logic       osc_fail_irq_enable;
   fsm_t       state;
   fsm_t       next_state;
   logic [5:0] div_cnt;
   logic       sample_clk;
   logic       fail_latch;
   logic [15:0] ost_cnt;

   // =========================================================
   // Sample clock
   localparam logic [5:0] DIV_LAST  = 6'(SAMPLE_DIV - 1);
   localparam logic [5:0] HALF_LAST = 6'(HALF_DIV - 1);

   wire div_half = lf_rise && (div_cnt == HALF_LAST);
   wire div_wrap = lf_rise && (div_cnt == DIV_LAST);
   wire samp_rise = div_wrap;
   wire samp_fall = div_half;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         div_cnt    <= 6'h00;
         sample_clk <= 1'b0;
      end else begin
         if (lf_rise) begin
            div_cnt <= div_cnt + 6'h01;
         end
         if (div_wrap) begin
            sample_clk <= 1'b1;
         end else if (div_half) begin
            sample_clk <= 1'b0;
         end
      end
   end

   // =========================================================
   // Fail detector
   // Set has priority so a low edge in the clear cycle counts
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fail_latch <= 1'b1;
      end else if (ext_fall) begin
         fail_latch <= 1'b1;
      end else if (samp_rise) begin
         fail_latch <= 1'b0;
      end
   end

   // Checked at sample low edge: a whole high half has passed
   wire fail_seen = samp_fall && !fail_latch && sample_clk;

   // =========================================================
   // Bus decode
   wire acc    = psel & penable & pready;
   wire wr     = acc & pwrite;
   wire hit_cfg = paddr == ADDR_CONFIG;
   wire hit_ctl = paddr == ADDR_OSCCTL;
   wire hit_st  = paddr == ADDR_STATUS;
   wire hit_fl  = paddr == ADDR_FLAGS;
   wire hit_en  = paddr == ADDR_ENABLES;
   wire mapped  = hit_cfg | hit_ctl | hit_st | hit_fl | hit_en;

   wire wr_cfg = wr & hit_cfg;
   wire wr_ctl = wr & hit_ctl;
   wire wr_fl  = wr & hit_fl;
   wire wr_en  = wr & hit_en;

   wire       new_scs  = pwdata[CTL_SCS_BIT];
   wire [2:0] new_internal_freq_select = pwdata[CTL_INTERNAL_FREQ_SELECT_LSB +: 3];
   wire       new_en   = pwdata[CFG_EN_BIT];
   wire [2:0] new_mode = pwdata[CFG_MODE_LSB +: 3];

   // A change of the select bit is the restart request
   wire scs_toggle = wr_ctl && (new_scs != ctl.scs_hi);

   // =========================================================
   // Start-up timer
   localparam logic [15:0] OST_LAST = 16'(OST_LEN - 1);

   wire ost_restart = wake_up | scs_toggle;
   wire ost_done    = ost_cnt == OST_LAST;
   wire ost_expire  = (state == ST_WAIT_OST) &&
                      (skip_ost(cfg.mode) ||
                       (ext_fall && ost_done));

   // Counts only external falls, so a dead oscillator never expires outside EC and RC modes
   wire ost_step = (state == ST_WAIT_OST) && ext_fall && !ost_done;

   always_ff @(posedge clk) begin
      if (!rst_n || ost_restart) begin
         ost_cnt <= 16'h0000;
      end else if (ost_step) begin
         ost_cnt <= ost_cnt + 16'h0001;
      end
   end

   // =========================================================
   // Fail-safe sequencer
   always_comb begin
      next_state = state;
      unique case (state)
         ST_WAIT_OST: begin
            if (ost_expire) begin
               next_state = ST_RUN_EXT;
            end
         end
         ST_RUN_EXT: begin
            if (ost_restart) begin
               next_state = ST_WAIT_OST;
            end else if (cfg.enable && fail_seen) begin
               next_state = ST_FAIL;
            end
         end
         ST_FAIL: begin
            // Stays here until wake_up or a firmware select toggle restarts the timer
            if (ost_restart) begin
               next_state = ST_WAIT_OST;
            end
         end
         default: begin
            next_state = ST_WAIT_OST;
         end
      endcase
   end

   wire fail_event = (state == ST_RUN_EXT) && (next_state == ST_FAIL);

   // Without the monitor the core waits on the external clock
   wire next_int = (next_state == ST_FAIL) ||
                   ((next_state == ST_WAIT_OST) && cfg.enable);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= ST_WAIT_OST;
      end else begin
         state <= next_state;
      end
   end

   // =========================================================
   // Software registers
   config_t  next_cfg;
   osc_ctl_t next_ctl;
   logic     next_irq_enable;
   logic     next_fail_flag;

   assign next_cfg = wr_cfg ? {new_mode, new_en} : cfg;
   assign next_ctl = wr_ctl ? {new_scs, new_internal_freq_select} : ctl;
   assign next_irq_enable = wr_en ? pwdata[FLAG_FAIL_BIT]
                                  : osc_fail_irq_enable;
   // Set wins over a same-cycle write of one
   assign next_fail_flag = fail_event ? 1'b1 :
                           (wr_fl && pwdata[FLAG_FAIL_BIT]) ? 1'b0 :
                           osc_fail_flag;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cfg.enable <= FCM_EN_RESET;
         cfg.mode   <= MODE_RESET;
      end else begin
         cfg <= next_cfg;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctl.scs_hi   <= 1'b0;
         ctl.freq_sel <= INTERNAL_FREQ_SELECT_RESET;
      end else begin
         ctl <= next_ctl;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         osc_fail_irq_enable <= 1'b0;
      end else begin
         osc_fail_irq_enable <= next_irq_enable;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         osc_fail_flag <= 1'b0;
      end else begin
         osc_fail_flag <= next_fail_flag;
      end
   end

   // =========================================================
   // Read mux
   wire [31:0] cfg_word = put_bit(cfg.enable, CFG_EN_BIT) |
                          put3(cfg.mode, CFG_MODE_LSB);
   wire [31:0] ctl_word = put_bit(ctl.scs_hi, CTL_SCS_BIT) |
                          put3(ctl.freq_sel, CTL_INTERNAL_FREQ_SELECT_LSB);
   // Status is read from the output flops, so it matches the pins
   wire [31:0] st_word  = put_bit(startup_settled_status, ST_SETTLED_BIT) |
                          put_bit(fail_safe_active, ST_FAILSAFE) |
                          put_bit(sys_clk_internal, ST_INTCLK_BIT);
   wire [31:0] fl_word  = put_bit(osc_fail_flag, FLAG_FAIL_BIT);
   wire [31:0] en_word  = put_bit(osc_fail_irq_enable, FLAG_FAIL_BIT);

   wire [31:0] rd_word =
      hit_cfg ? cfg_word :
      hit_ctl ? ctl_word :
      hit_st  ? st_word :
      hit_fl  ? fl_word :
      hit_en  ? en_word :
      WORD_ZERO;

   // =========================================================
   // APB slave: one wait state per access
   wire        apb_wait     = psel && penable && !pready;
   wire        next_pslverr = apb_wait && !mapped;
   wire [31:0] next_prdata  = (apb_wait && !pwrite && mapped) ? rd_word
                                                             : WORD_ZERO;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= WORD_ZERO;
      end else begin
         pready  <= apb_wait;
         pslverr <= next_pslverr;
         prdata  <= next_prdata;
      end
   end

   // =========================================================
   // Outputs
   wire next_irq     = osc_fail_flag & osc_fail_irq_enable;
   wire next_settled = next_state == ST_RUN_EXT;
   wire next_fsafe   = next_state == ST_FAIL;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= next_irq;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sys_clk_internal <= 1'b0;
      end else begin
         sys_clk_internal <= next_int;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         internal_freq_select <= INTERNAL_FREQ_SELECT_RESET;
      end else begin
         internal_freq_select <= ctl.freq_sel;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         startup_settled_status <= 1'b0;
      end else begin
         startup_settled_status <= next_settled;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fail_safe_active <= 1'b0;
      end else begin
         fail_safe_active <= next_fsafe;
      end
   end

endmodule // fail_safe_clock_monitor

`default_nettype wire

// >>> core/fail_safe_clock_monitor_pkg.sv
package fail_safe_clock_monitor_pkg;

   // =========================================================
   // Register map (byte addresses, one word each)
   localparam logic [7:0] ADDR_CONFIG  = 8'h00;
   localparam logic [7:0] ADDR_OSCCTL  = 8'h04;
   localparam logic [7:0] ADDR_STATUS  = 8'h08;
   localparam logic [7:0] ADDR_FLAGS   = 8'h0c;
   localparam logic [7:0] ADDR_ENABLES = 8'h10;

   // =========================================================
   // Field positions
   localparam int CFG_EN_BIT     = 0;
   localparam int CFG_MODE_LSB   = 4;
   localparam int CTL_INTERNAL_FREQ_SELECT_LSB   = 0;
   localparam int CTL_SCS_BIT    = 4;
   localparam int ST_SETTLED_BIT = 0;
   localparam int ST_FAILSAFE    = 1;
   localparam int ST_INTCLK_BIT  = 2;
   localparam int FLAG_FAIL_BIT  = 0;

   // =========================================================
   // External oscillator modes
   localparam logic [2:0] MODE_LP = 3'h0;
   localparam logic [2:0] MODE_XT = 3'h1;
   localparam logic [2:0] MODE_HS = 3'h2;
   localparam logic [2:0] MODE_EC = 3'h3;
   localparam logic [2:0] MODE_RC = 3'h4;

   // =========================================================
   // Reset values and timing
   localparam logic [2:0]  INTERNAL_FREQ_SELECT_RESET    = 3'h3;
   localparam logic [2:0]  MODE_RESET    = 3'h2;
   localparam logic        FCM_EN_RESET  = 1'h1;
   localparam int          SAMPLE_DIV    = 64;
   localparam int          HALF_DIV      = SAMPLE_DIV / 2;
   localparam int          OST_CYCLES    = 1024;
   localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;

   // =========================================================
   // Grouped control fields
   typedef struct packed {
      logic [2:0] mode;
      logic       enable;
   } config_t;

   typedef struct packed {
      logic       scs_hi;
      logic [2:0] freq_sel;
   } osc_ctl_t;

   typedef enum logic [2:0] {
      ST_WAIT_OST = 3'b001,
      ST_RUN_EXT  = 3'b010,
      ST_FAIL     = 3'b100
   } fsm_t;

endpackage

// >>> tb/fail_safe_clock_monitor_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Port checks of the clock monitor
module fail_safe_clock_monitor_assertions
   import fail_safe_clock_monitor_pkg::*;
#(
   parameter int OST_LEN = OST_CYCLES
)(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        wake_up,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        sys_clk_internal,
   input wire logic [2:0]  internal_freq_select,
   input wire logic        startup_settled_status,
   input wire logic        fail_safe_active
);
   wire logic wr_ctl = psel & penable & pready & pwrite
                       & (paddr == ADDR_OSCCTL);
   wire logic mapped = (paddr <= ADDR_ENABLES) & (paddr[1:0] == 2'b00);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_wait;
      psel && penable && !pready;
   endsequence
   // Register write lands, then state, then outputs: allow three edges
   sequence s_ctl_write;
      $past(wr_ctl) || $past(wr_ctl, 2) || $past(wr_ctl, 3);
   endsequence
   sequence s_restart;
      $past(wr_ctl) || $past(wr_ctl, 2) || $past(wr_ctl, 3) || $past(wake_up)
         || $past(wake_up, 2) || $past(wake_up, 3);
   endsequence

   a_ready_wait: assert property (s_wait |=> pready)
      else $error("no ready after access phase");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_refuse_unmapped: assert property ((s_wait and !mapped) |=>
      pslverr && prdata == WORD_ZERO)
      else $error("unmapped access not refused");
   a_fail_internal: assert property (
      fail_safe_active |-> sys_clk_internal)
      else $error("fail-safe without internal clock");
   a_fail_after_ost: assert property (
      $rose(fail_safe_active) |-> $past(startup_settled_status))
      else $error("failure taken before timer expiry");
   a_settled_external: assert property (
      startup_settled_status |-> !sys_clk_internal && !fail_safe_active)
      else $error("settled but not on external clock");
   a_no_auto_return: assert property (
      $fell(fail_safe_active) |-> s_restart)
      else $error("fail-safe left without restart");
   a_freq_by_write: assert property (
      $changed(internal_freq_select) |-> s_ctl_write)
      else $error("frequency select moved unasked");
endmodule // fail_safe_clock_monitor_assertions

bind fail_safe_clock_monitor fail_safe_clock_monitor_assertions #(.OST_LEN(OST_LEN)) u_chk (
   .clk(clk), .rst_n(rst_n), .wake_up(wake_up), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .sys_clk_internal(sys_clk_internal),
   .internal_freq_select(internal_freq_select),
   .startup_settled_status(startup_settled_status),
   .fail_safe_active(fail_safe_active)
);
`default_nettype wire

// >>> tb/ext_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// External oscillator; a dead one sticks high, so no falling edges
module ext_osc_model #(
   parameter int HALF_NS = 80
)(
   input wire logic run,
   output var logic ext_osc
);
   initial begin
      ext_osc = 1'b1;
      forever begin
         #HALF_NS;
         ext_osc = run ? ~ext_osc : 1'b1;
      end
   end
endmodule // ext_osc_model
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb import fail_safe_clock_monitor_pkg::*;;
   logic        clk, rst_n, slow_osc, wake_up, run, ext_osc, e;
   logic        psel, penable, pwrite, pready, pslverr, irq;
   logic        int_clk, settled, fsafe;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   logic [2:0]  freq_sel, f;
   logic [31:0] mdl [5];
   int          err_total, samples_checked, m;

   ext_osc_model #(.HALF_NS(80)) u_osc (.run(run), .ext_osc(ext_osc));
   fail_safe_clock_monitor #(.OST_LEN(8)) DUT (
      .clk(clk), .rst_n(rst_n), .ext_osc(ext_osc),
      .low_freq_internal_osc(slow_osc), .wake_up(wake_up), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .sys_clk_internal(int_clk), .internal_freq_select(freq_sel),
      .startup_settled_status(settled), .fail_safe_active(fsafe));

   initial begin clk = 0; forever #20 clk = ~clk; end
   initial begin slow_osc = 0; forever #80 slow_osc = ~slow_osc; end

   // ========================================
   // Bus and compare helpers
   task automatic chk(input logic [31:0] got, exp, input string msg);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x,
                     input logic xe);
      apb(1'b0, a, WORD_ZERO);
      chk(r, x, "read data");
      chk(e, xe, "slave error");
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      mdl[a[4:2]] = d;
   endtask
   task automatic cyc(input int n); repeat (n) @(negedge clk); endtask
   task automatic wt(input int s, input int lim);
      int n;
      n = 0;
      while ((s == 0 ? fsafe : settled) !== 1'b1 && n < lim) begin
         @(negedge clk);
         n++;
      end
      chk(s == 0 ? fsafe : settled, 1'b1, "wait for state");
   endtask
   task automatic stop_test;
      $display("checked %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      $display("[FAIL] %0t watchdog expired", $time);
      stop_test;
   end

   // ========================================
   // Scenarios
   initial begin
      rst_n = 0; wake_up = 0; run = 1; psel = 0; penable = 0; pwrite = 0;
      paddr = 8'h00; pwdata = WORD_ZERO; err_total = 0; samples_checked = 0;
      mdl[0] = {25'h0, MODE_RESET, 3'h0, FCM_EN_RESET};
      mdl[1] = {29'h0, INTERNAL_FREQ_SELECT_RESET};
      void'($urandom(41));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      cyc(2);
      chk(int_clk, 1'b1, "two speed start");
      chk(settled, 1'b0, "timer running");
      rd(ADDR_CONFIG, mdl[0], 1'b0);
      rd(ADDR_OSCCTL, mdl[1], 1'b0);
      rd(8'h14, WORD_ZERO, 1'b1);
      wt(1, 300);
      chk(int_clk, 1'b0, "external clock");
      rd(ADDR_STATUS, 32'h1, 1'b0);
      wr(ADDR_ENABLES, 32'h1);
      run <= 1'b0;
      wt(0, 1000);
      chk(int_clk, 1'b1, "switched internal");
      cyc(2);
      chk(irq, 1'b1, "irq raised");
      rd(ADDR_FLAGS, 32'h1, 1'b0);
      run <= 1'b1;
      cyc(600);
      chk(fsafe, 1'b1, "no return");
      wr(ADDR_FLAGS, 32'h1);
      rd(ADDR_FLAGS, WORD_ZERO, 1'b0);
      chk(irq, 1'b0, "irq cleared");
      chk(fsafe, 1'b1, "still fail-safe");
      f = 3'($urandom);
      wr(ADDR_OSCCTL, {27'h0, 1'b1, 1'b0, f});
      cyc(3);
      chk(freq_sel, f, "frequency select");
      chk(int_clk, 1'b1, "internal while timer");
      wt(1, 300);
      chk(fsafe, 1'b0, "fail-safe ended");
      wr(ADDR_ENABLES, WORD_ZERO);
      // Timer modes must still be counting five cycles after wake
      for (m = 0; m < 5; m++) begin
         wr(ADDR_CONFIG, {25'h0, m[2:0], 4'h1});
         @(posedge clk);
         wake_up <= 1'b1;
         @(posedge clk);
         wake_up <= 1'b0;
         cyc(5);
         chk(settled, m > 2, "timer skip by mode");
         wt(1, 300);
      end
      run <= 1'b0;
      wt(0, 1000);
      rd(ADDR_FLAGS, 32'h1, 1'b0);
      chk(irq, 1'b0, "irq masked");
      wr(ADDR_ENABLES, 32'h1);
      cyc(2);
      chk(irq, 1'b1, "irq unmasked");
      wr(ADDR_CONFIG, {25'h0, MODE_HS, 4'h0});
      wr(ADDR_OSCCTL, {27'h0, 1'b0, 1'b0, f});
      run <= 1'b1;
      wt(1, 300);
      rd(ADDR_CONFIG, mdl[0], 1'b0);
      run <= 1'b0;
      cyc(700);
      chk(fsafe, 1'b0, "monitor disabled");
      stop_test;
   end
endmodule // tb
`default_nettype wire
